// ===== logic/hrw_defines.vh
// Purpose: constants and register map of the hub remote wake indicator block
// Assumes: pclk at 10 MHz, APB slave with 32-bit data
// Notes:   registers take one aligned word each; unused bits read as zero
`ifndef HRW_DEFINES_VH
`define HRW_DEFINES_VH

// ----------------------------------------
// registers
// ----------------------------------------
`define HRW_CTRL_ADDR     12'h000
`define HRW_STATUS_ADDR   12'h004
`define HRW_MASK_ADDR     12'h008
`define HRW_PULSE_ADDR    12'h00C
`define HRW_STATE_ADDR    12'h010

// ctrl fields
`define HRW_CTRL_INHIBIT  0
`define HRW_CTRL_RWAKE_EN 1
`define HRW_CTRL_SUSPEND  2
`define HRW_CTRL_RESET    32'h0000_0000

// status / mask fields
`define HRW_ST_WAKE       0
`define HRW_ST_HOSTK      1
`define HRW_ST_TIMEOUT    2
`define HRW_ST_PWR        3
`define HRW_ST_W          4

// ----------------------------------------
// timing
// ----------------------------------------
`define HRW_CLK_KHZ       10000
`define HRW_FILT_US       100
`define HRW_FILT_CYC      ((`HRW_FILT_US * `HRW_CLK_KHZ + 999) / 1000)
`define HRW_PULSE_MS      14
`define HRW_PULSE_CYC     (`HRW_PULSE_MS * `HRW_CLK_KHZ)
// same span as a 24-bit load value for the timers
`define HRW_PULSE_LEN     24'h02_22E0
`define HRW_EOP_CYC       20

`endif

// ===== logic/hrw_filter.v
// Purpose: per-port resume filter, a level must hold before it counts
// Assumes: input synchronous to pclk
// Notes:   emits one pulse when the filtered level rises
`include "hrw_defines.vh"

module hrw_filter
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// event level and filtered pulse
	input  wire        raw,
	output reg         hit
);
	reg  [10:0] cnt_q;
	reg         done_q;

	// ----------------------------------------
	// filter counter
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= 11'h000;
			done_q <= 1'b0;
			hit    <= 1'b0;
		end
		else
		begin
			hit <= 1'b0;
			if (!raw)
			begin
				cnt_q  <= 11'h000;
				done_q <= 1'b0;
			end
			else if (!done_q)
			begin
				// glitches shorter than the window are dropped
				if (cnt_q == `HRW_FILT_CYC - 1)
				begin
					done_q <= 1'b1;
					hit    <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 11'h001;
			end
		end
	end
endmodule

// ===== logic/hrw_timer.v
// Purpose: loadable down counter for indicator pulse and resume window
// Assumes: load value nonzero
// Notes:   expired is a one-cycle pulse on reaching zero
`include "hrw_defines.vh"

module hrw_timer
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// control
	input  wire        load,
	input  wire [23:0] len,
	input  wire        stop,
	// state
	output wire        running,
	output reg         expired
);
	reg  [23:0] cnt_q;

	assign running = (cnt_q != 24'h00_0000);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q   <= 24'h00_0000;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (load)
				cnt_q <= len;
			else if (stop)
				cnt_q <= 24'h00_0000;
			else if (running)
			begin
				cnt_q <= cnt_q - 24'h00_0001;
				if (cnt_q == 24'h00_0001)
					expired <= 1'b1;
			end
		end
	end
endmodule

// ===== logic/hrw_top.v
// Purpose: resume and wake indication of a four-port hub, modified resume mode
// Assumes: link signals synchronous to pclk; APB master keeps protocol
// Notes:   APB answers with no wait states; unmapped reads give zero
`include "hrw_defines.vh"

module hrw_top
(
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq,
	// upstream
	input  wire        host_power_sense,
	input  wire        up_high_speed,
	input  wire        up_k_detect,
	input  wire        proto_resume_req,
	output reg         dp_pullup_en,
	output reg         up_drive_k,
	output reg         suspend_wake_indicator,
	// speed indicator pin, shared with strap
	input  wire        speed_indicator_in,
	output reg         speed_indicator_out,
	output wire        speed_indicator_oe_n,
	output reg         config_select_strap_bit,
	// downstream ports
	input  wire [3:0]  dn_disconnect,
	input  wire [3:0]  dn_connect,
	input  wire [3:0]  dn_wake_req,
	input  wire [3:0]  dn_port_change,
	output reg  [3:0]  dn_drive_k,
	output reg  [3:0]  dn_send_eop,
	output wire [3:0]  dn_port_power
);
	// ----------------------------------------
	// state machine codes
	// ----------------------------------------
	localparam [4:0] S_IDLE  = 5'b00001;
	localparam [4:0] S_CTRL  = 5'b00010;
	localparam [4:0] S_HOST  = 5'b00100;
	localparam [4:0] S_END   = 5'b01000;
	localparam [4:0] S_PROTO = 5'b10000;

	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg  [2:0]  ctrl_q;
	reg  [3:0]  status_q;
	reg  [3:0]  mask_q;
	reg  [23:0] pulse_len_q;
	reg  [3:0]  wake_ports_q;
	reg  [4:0]  eop_cnt_q;
	reg         strap_done_q;
	reg         lock_q;
	reg         pwr_q;
	wire [3:0]  hit;
	wire        pulse_run;
	wire        win_run;
	wire        win_exp;
	wire        wr;
	wire        rd;
	wire        inhibit;
	wire        any_wake;
	wire        accept;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~pwrite;
	assign irq     = |(status_q & mask_q);
	assign inhibit = ctrl_q[`HRW_CTRL_INHIBIT];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd && !penable)
		begin
			case (paddr)
				`HRW_CTRL_ADDR:   prdata <= {29'h0, ctrl_q};
				`HRW_STATUS_ADDR: prdata <= {28'h0, status_q};
				`HRW_MASK_ADDR:   prdata <= {28'h0, mask_q};
				`HRW_PULSE_ADDR:  prdata <= {8'h00, pulse_len_q};
				`HRW_STATE_ADDR:  prdata <= {21'h0, config_select_strap_bit,
				                              wake_ports_q, dp_pullup_en, state_q};
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q       <= 3'b000;
			mask_q       <= 4'h0;
			pulse_len_q  <= `HRW_PULSE_LEN;
			strap_done_q <= 1'b0;
			lock_q       <= 1'b0;
		end
		else
		begin
			strap_done_q <= 1'b1;
			if (wr && paddr == `HRW_CTRL_ADDR)
			begin
				// inhibit is write-once after reset, then frozen like a strap
				if (!lock_q)
					ctrl_q[`HRW_CTRL_INHIBIT] <= pwdata[`HRW_CTRL_INHIBIT];
				lock_q      <= 1'b1;
				ctrl_q[2:1] <= pwdata[2:1];
			end
			if (wr && paddr == `HRW_MASK_ADDR)
				mask_q <= pwdata[3:0];
			if (wr && paddr == `HRW_PULSE_ADDR && pwdata[23:0] != 24'h00_0000)
				pulse_len_q <= pwdata[23:0];
		end
	end

	// ----------------------------------------
	// strap capture and speed indicator
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config_select_strap_bit <= 1'b0;
			speed_indicator_out     <= 1'b0;
		end
		else
		begin
			if (!strap_done_q)
				config_select_strap_bit <= speed_indicator_in;
			// polarity from strap asserted at high speed
			speed_indicator_out <= up_high_speed ^ config_select_strap_bit;
		end
	end
	// pin released while the strap is sampled
	assign speed_indicator_oe_n = ~strap_done_q;

	// ----------------------------------------
	// downstream event filters
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : port
			hrw_filter u_filt
			(
				.pclk    (pclk),
				.presetn (presetn),
				.raw     (dn_disconnect[g] | dn_connect[g] | dn_wake_req[g]),
				.hit     (hit[g])
			);
		end
	endgenerate

	// ports stay powered whatever host power does
	assign dn_port_power = 4'hF;
	assign any_wake = |(hit & dn_port_change);
	// accept only if enabled and suspended, one pulse per event; idle upstream K on any_wake ignores both
	assign accept = any_wake & ctrl_q[`HRW_CTRL_RWAKE_EN] & ctrl_q[`HRW_CTRL_SUSPEND]
	                & ~pulse_run;

	// ----------------------------------------
	// timers
	// ----------------------------------------
	hrw_timer u_pulse
	(
		.pclk    (pclk),
		.presetn (presetn),
		.load    (accept),
		.len     (pulse_len_q),
		.stop    (1'b0),
		.running (pulse_run),
		.expired ()
	);

	hrw_timer u_window
	(
		.pclk    (pclk),
		.presetn (presetn),
		.load    (accept & inhibit),
		.len     (`HRW_PULSE_LEN),
		.stop    (state_q != S_CTRL),
		.running (win_run),
		.expired (win_exp)
	);

	// ----------------------------------------
	// resume state machine
	// ----------------------------------------
	always @*
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE:
			begin
				if (accept && inhibit)
					state_d = S_CTRL;
				else if (proto_resume_req && host_power_sense)
					state_d = S_PROTO;
			end
			S_CTRL:
			begin
				if (up_k_detect && host_power_sense)
					state_d = S_HOST;
				else if (win_exp)
					state_d = S_END;
			end
			S_HOST:
				if (!up_k_detect)
					state_d = S_IDLE;
			S_END:
				if (eop_cnt_q == `HRW_EOP_CYC - 1)
					state_d = S_IDLE;
			S_PROTO:
				if (!proto_resume_req || !host_power_sense)
					state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= S_IDLE;
			wake_ports_q <= 4'h0;
			eop_cnt_q    <= 5'h00;
		end
		else
		begin
			state_q <= state_d;
			if (accept && inhibit)
				wake_ports_q <= hit & dn_port_change;
			else if (state_q == S_CTRL)
				wake_ports_q <= wake_ports_q | (hit & dn_port_change);
			if (state_q == S_END)
				eop_cnt_q <= eop_cnt_q + 5'h01;
			else
				eop_cnt_q <= 5'h00;
		end
	end

	// ----------------------------------------
	// link outputs
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dp_pullup_en           <= 1'b0;
			up_drive_k             <= 1'b0;
			dn_drive_k             <= 4'h0;
			dn_send_eop            <= 4'h0;
			suspend_wake_indicator <= 1'b0;
			pwr_q                  <= 1'b0;
		end
		else
		begin
			pwr_q <= host_power_sense;
			// pull-up follows host power; no internal reset on loss
			dp_pullup_en <= host_power_sense;
			// never K upstream without host power: could back drive the host
			up_drive_k <= host_power_sense &
			              ((state_q == S_PROTO) | (state_q == S_IDLE && !inhibit && any_wake));
			case (state_q)
				S_CTRL:  dn_drive_k <= wake_ports_q;
				S_HOST:  dn_drive_k <= 4'hF;
				S_PROTO: dn_drive_k <= 4'hF;
				default: dn_drive_k <= 4'h0;
			endcase
			dn_send_eop <= (state_q == S_END) ? wake_ports_q : 4'h0;
			// suspended level, inverted by the wake pulse while timer runs
			suspend_wake_indicator <= ctrl_q[`HRW_CTRL_SUSPEND] ^ pulse_run;
		end
	end

	// ----------------------------------------
	// interrupt status, write one to clear, set wins
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= 4'h0;
		else
			status_q <= (status_q & ~((wr && paddr == `HRW_STATUS_ADDR) ? pwdata[3:0] : 4'h0))
			            | {pwr_q ^ host_power_sense, win_exp,
			               state_q == S_CTRL && state_d == S_HOST, accept};
	end
endmodule

// ===== test/hrw_chk.sv
// Purpose: port assertions for the hub wake block
// Assumes: one clock domain, async active-low reset
// Notes:   sees only top-level ports
module hrw_chk
(
	// clock and reset
	input logic       pclk,
	input logic       presetn,
	// watched ports
	input logic       host_power_sense,
	input logic       up_high_speed,
	input logic       proto_resume_req,
	input logic       dp_pullup_en,
	input logic       up_drive_k,
	input logic       suspend_wake_indicator,
	input logic       speed_indicator_out,
	input logic       speed_indicator_oe_n,
	input logic       config_select_strap_bit,
	input logic [3:0] dn_drive_k,
	input logic [3:0] dn_send_eop,
	input logic [3:0] dn_port_power
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_pullup_follows: assert property (1 |=> dp_pullup_en == $past(host_power_sense))
		else $error("pull-up not following host power");
	a_ports_powered: assert property (dn_port_power == 4'hf)
		else $error("downstream port power dropped");
	// two edges of settling: strap latch lands on the first
	a_strap_held: assert property ($past(presetn, 2) |-> $stable(config_select_strap_bit))
		else $error("latched strap changed");
	a_pin_driven: assert property ($past(presetn, 2) |-> !speed_indicator_oe_n)
		else $error("speed pin not driven");
	a_speed_polarity: assert property ($past(presetn, 2) |->
		speed_indicator_out == ($past(up_high_speed) ^ config_select_strap_bit))
		else $error("speed indicator level wrong");
	a_no_up_k: assert property (!host_power_sense [*2] |-> !up_drive_k)
		else $error("upstream K without host power");
	a_eop_not_k: assert property ((dn_send_eop & dn_drive_k) == 4'h0)
		else $error("EOP and K on one port");
	a_k_on_request: assert property (host_power_sense && proto_resume_req |-> ##[1:2] up_drive_k)
		else $error("upstream K missing");
	cover property ($fell(suspend_wake_indicator));
	cover property ($rose(up_drive_k));
	cover property ($fell(dp_pullup_en));
endmodule

bind hrw_top hrw_chk hrw_chk_i (.pclk, .presetn, .host_power_sense, .up_high_speed,
	.proto_resume_req, .dp_pullup_en, .up_drive_k, .suspend_wake_indicator,
	.speed_indicator_out, .speed_indicator_oe_n, .config_select_strap_bit, .dn_drive_k,
	.dn_send_eop, .dn_port_power);

// ===== test/hrw_far_model.sv
// Purpose: downstream devices and upstream host seen by the hub
// Assumes: bench pulses go for one cycle
// Notes:   released lines fall back to idle low
module hrw_far_model
(
	// clock
	input  logic        pclk,
	// commands
	input  logic        go,
	input  logic [1:0]  kind,
	input  logic [3:0]  wake_port,
	input  logic [15:0] hold,
	input  logic        host_power_sense,
	input  logic        host_k_req,
	// lines toward the hub
	output logic [3:0]  dn_disconnect,
	output logic [3:0]  dn_connect,
	output logic [3:0]  dn_wake_req,
	output logic [3:0]  dn_port_change,
	output logic        up_k_detect
);
	logic [15:0] cnt_q;
	logic        live;
	initial cnt_q = 16'h0000;
	always @(posedge pclk)
		if (go)
			cnt_q <= hold;
		else if (cnt_q != 16'h0000)
			cnt_q <= cnt_q - 16'h0001;
	assign live = (cnt_q != 16'h0000);
	// one device, one of the three wake kinds
	assign dn_disconnect = (live && kind == 2'd0) ? wake_port : 4'h0;
	assign dn_connect = (live && kind == 2'd1) ? wake_port : 4'h0;
	assign dn_wake_req = (live && kind == 2'd2) ? wake_port : 4'h0;
	assign dn_port_change = live ? wake_port : 4'h0;
	// a powered-down host cannot answer with K
	assign up_k_detect = host_power_sense & host_k_req;
endmodule

// ===== test/hub_remote_wake_indicator_tb.sv
// Purpose: self-checking bench of the hub wake block
// Assumes: zero-wait APB slave, pulse length register set small
// Notes:   resume window timeout is too long to reach here
module hub_remote_wake_indicator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        host_power_sense, up_high_speed, proto_resume_req, up_k_detect;
	logic        dp_pullup_en, up_drive_k, suspend_wake_indicator, strap_pull, pin;
	logic        speed_indicator_out, speed_indicator_oe_n, config_select_strap_bit;
	logic        go, host_k_req;
	logic [1:0]  kind;
	logic [3:0]  wake_port, dn_disconnect, dn_connect, dn_wake_req, dn_port_change;
	logic [3:0]  dn_drive_k, dn_send_eop, dn_port_power;
	logic [15:0] hold;
	int          errors, comparisons, n;
	// shared pin: strap resistor wins while the hub is not driving
	assign pin = speed_indicator_oe_n ? strap_pull : speed_indicator_out;
	hrw_top hrw_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .host_power_sense, .up_high_speed, .up_k_detect,
		.proto_resume_req, .dp_pullup_en, .up_drive_k, .suspend_wake_indicator,
		.speed_indicator_in(pin), .speed_indicator_out, .speed_indicator_oe_n,
		.config_select_strap_bit, .dn_disconnect, .dn_connect, .dn_wake_req,
		.dn_port_change, .dn_drive_k, .dn_send_eop, .dn_port_power);
	hrw_far_model hrw_far_model_i (.pclk, .go, .kind, .wake_port, .hold, .host_power_sense,
		.host_k_req, .dn_disconnect, .dn_connect, .dn_wake_req, .dn_port_change,
		.up_k_detect);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse_go;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_strap;
		chk(config_select_strap_bit, 1);
		chk(dp_pullup_en, 1);
		up_high_speed <= 1'b1;
		cyc(3);
		chk(pin, 0);
		up_high_speed <= 1'b0;
		cyc(3);
		chk(pin, 1);
	endtask
	task t_regs;
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk(rd, 32'h0002_22E0);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// inhibit is frozen by the first ctrl write after reset, so this write leaves it clear
		apb(1'b1, 12'h000, 32'h0000_0007);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0006);
		apb(1'b1, 12'h00C, 32'h0000_0032);
		apb(1'b1, 12'h008, 32'h0000_0001);
	endtask
	task t_power;
		host_power_sense <= 1'b0;
		cyc(3);
		chk(dp_pullup_en, 0);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0006);
	endtask
	task t_wake(input logic [1:0] k);
		int lo;
		kind <= k;
		wake_port <= 4'h1 << k;
		hold <= 16'h01F4;
		pulse_go;
		cyc(600);
		chk(suspend_wake_indicator, 1);
		hold <= 16'h04B0;
		pulse_go;
		n = 0;
		while (suspend_wake_indicator === 1'b1 && n < 2000)
		begin
			@(negedge pclk);
			n++;
		end
		chk(n >= 1000 && n < 2000, 1);
		lo = 0;
		// window spans the release of the wake level too
		repeat (500)
		begin
			@(negedge pclk);
			lo += (suspend_wake_indicator === 1'b0);
		end
		chk(lo + 1, 50);
		chk(irq, 1);
		apb(1'b1, 12'h008, 32'h0000_0000);
		cyc(1);
		chk(irq, 0);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd[0], 1);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0001);
		cyc(1);
		chk(irq, 0);
	endtask
	task t_kreq;
		host_power_sense <= 1'b1;
		proto_resume_req <= 1'b1;
		host_k_req <= 1'b1;
		cyc(4);
		chk(up_drive_k, 1);
		proto_resume_req <= 1'b0;
		host_power_sense <= 1'b0;
		cyc(4);
		chk(up_drive_k, 0);
	endtask
	task t_ctrl;
		host_power_sense <= 1'b0;
		host_k_req <= 1'b0;
		presetn <= 1'b0;
		cyc(3);
		presetn <= 1'b1;
		cyc(2);
		apb(1'b1, 12'h000, 32'h0000_0007);
		kind <= 2'd2;
		wake_port <= 4'h4;
		hold <= 16'h04B0;
		pulse_go;
		n = 0;
		while (dn_drive_k !== 4'h4 && n < 2000)
		begin
			@(negedge pclk);
			n++;
		end
		chk(dn_drive_k, 4'h4);
		chk(up_drive_k, 0);
		chk(suspend_wake_indicator, 0);
		@(posedge pclk);
		host_power_sense <= 1'b1;
		host_k_req <= 1'b1;
		cyc(4);
		@(negedge pclk);
		chk(dn_drive_k, 4'hF);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd[1], 1);
		host_k_req <= 1'b0;
		cyc(3);
		@(negedge pclk);
		chk(dn_drive_k, 4'h0);
	endtask
	task test_done;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// whole run is well under 20000 cycles
	initial
	begin
		#2_000_000;
		errors++;
		test_done;
	end
	initial
	begin
		{psel, penable, pwrite, go, host_k_req, up_high_speed, proto_resume_req} = 7'h00;
		{paddr, pwdata, hold, kind, wake_port} = 0;
		{errors, comparisons} = 0;
		host_power_sense = 1'b1;
		strap_pull = 1'b1;
		presetn = 1'b0;
		cyc(10);
		presetn <= 1'b1;
		cyc(2);
		t_strap;
		apb(1'b1, 12'h000, 32'h0000_0006);
		t_regs;
		t_power;
		for (int k = 0; k < 3; k++)
			t_wake(k[1:0]);
		t_kreq;
		t_ctrl;
		test_done;
	end
endmodule
